// *** rtl/dac_host_ctrl.sv ***
// Purpose: host side sequencer for a mode controlled dram driver
// Assumes: driver pins are on ref_clk timing; refresh io pin is async
// Notes: software orders accesses and refresh policy over avalon-mm
`timescale 1ns/100ps
module dac_host_ctrl #(
  parameter int ADDR_W = 20,
  parameter int CYCLE_PERIOD = dac_pkg::CYCLE_PERIOD,
  parameter int CYCLE_HIGH = dac_pkg::CYCLE_HIGH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [ADDR_W-1:0] memAddr,
  output logic rowStrobeInN,
  output logic colStrobeOrRefClk,
  output logic rowColOrCycleClk,
  output logic writeInN,
  output logic refreshModePin,
  output logic lowModePin,
  output logic rowHoldSelect,
  input wire logic refreshIoIn,
  output logic refreshIoOut,
  output logic refreshIoOe
);
  // cycle figures in counter width
  localparam logic [7:0] ROW_HOLD = 8'(dac_pkg::ROW_HOLD_CYC);
  localparam logic [7:0] COL_LOW = 8'(dac_pkg::COL_LOW_CYC);
  localparam logic [7:0] PRECH = 8'(dac_pkg::PRECHARGE_CYC);
  localparam logic [7:0] RAS_LOW = 8'(dac_pkg::RAS_LOW_CYC);
  localparam logic [7:0] AUTO_LOW = 8'(dac_pkg::AUTO_LOW_CYC);
  localparam logic [7:0] RF_SETUP = 8'(dac_pkg::REFRESH_SELECT_SETUP_CYC);
  localparam logic [7:0] FORCE_MAX = 8'(dac_pkg::FORCE_MAX_CYC);
  // bounds for the assertions
  localparam int FORCE_LIM = dac_pkg::FORCE_MAX_CYC + 2;
  localparam int PRECH_LIM = dac_pkg::PRECHARGE_CYC + 2;
  localparam int PRECH_MIN = dac_pkg::PRECHARGE_CYC;

  // whole state of the controller
  typedef struct packed {
    dac_pkg::dac_state_t st;   // sequencer state
    logic [7:0] cnt;           // timing down counter
    logic extMode;             // external access chosen
    logic rowHold;             // row hold select level
    logic autoRef;             // hidden plus forced refresh on
    logic [ADDR_W-1:0] addr;   // access address for the driver
    logic isWrite;             // current access writes
    logic rdAck;               // read answer cycle
    logic [31:0] rdata;        // read data flop
    logic ioS1;                // refresh io sync, first stage
    logic ioS2;                // refresh io sync, second stage
    logic ioPrev;              // delayed copy for falling edge
    logic refPend;             // refresh owed
    logic [3:0] clrCnt;        // counter reset pulse timer
    logic [15:0] refCount;     // copy of the device refresh count
    logic rowN;                // row strobe input level
    logic colN;                // column strobe input level
    logic winN;                // write input level
    logic rcSel;               // row/column select level
    logic [1:0] mode;          // mode pin pair
  } dac_regs_t;
  dac_regs_t q, d;

  logic strobeClk;   // refresh strobe clock
  logic cycleClk;    // refresh cycle clock
  logic cycleFall;   // one pulse as the cycle clock falls
  logic ioFall;      // synced request edge
  logic refSet;      // refresh becomes owed
  logic refClr;      // refresh taken
  logic cmdHit;      // write aimed at the command word
  logic cmdGo;       // access command accepted
  logic busy;        // sequencer not idle
  logic [31:0] readMux;

  // refresh clocks, shared by hidden and scheduled refresh
  dac_clk_gen #(
    .STROBE_HALF(dac_pkg::STROBE_HALF),
    .CYCLE_PERIOD(CYCLE_PERIOD),
    .CYCLE_HIGH(CYCLE_HIGH)
  ) u_clk_gen (
    .ref_clk(ref_clk),
    .reset(reset),
    .strobeClk(strobeClk),
    .cycleClk(cycleClk),
    .cycleFall(cycleFall)
  );

  // bus handshake: reads answer one cycle late, commands stall
  always_comb begin
    busy = (q.st != dac_pkg::ST_IDLE);
    cmdHit = avs_write & (avs_address == dac_pkg::REG_CMD);
    // request edge ignored while we pull the pin ourselves
    ioFall = q.ioPrev & ~q.ioS2 & (q.clrCnt == 4'h0);
    // scheduled refresh unless hidden plus forced is active
    refSet = (q.extMode | ~q.autoRef) ? cycleFall : ioFall;
    // wait states while refresh is owed or running
    avs_waitrequest = (avs_read & ~q.rdAck)
      | (cmdHit & (busy | q.refPend | refSet));
    cmdGo = cmdHit & ~avs_waitrequest & avs_writedata[dac_pkg::CMD_GO];
  end

  // read data selection, decoded by word index
  always_comb begin
    if (avs_address == dac_pkg::REG_CTRL) begin
      readMux = {29'h0, q.autoRef, q.rowHold, q.extMode};
    end else if (avs_address == dac_pkg::REG_ADDR) begin
      readMux = 32'(q.addr);
    end else if (avs_address == dac_pkg::REG_CMD) begin
      readMux = {30'h0, q.isWrite, busy};
    end else begin
      readMux = {q.refCount, 12'h000, q.ioS2, q.refPend, busy, q.extMode};
    end
  end

  // next state of everything
  always_comb begin
    d = q;
    refClr = 1'b0;
    // two stage sync of the async request pin
    d.ioS1 = refreshIoIn;
    d.ioS2 = q.ioS1;
    d.ioPrev = q.ioS2;
    d.rdAck = avs_read & ~q.rdAck;
    d.rdata = readMux;
    if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end
    if (q.clrCnt != 4'h0) begin
      d.clrCnt = q.clrCnt - 4'h1;
    end
    // control word; mode pins pick up extMode only in the idle and external refresh end states
    if (avs_write && avs_address == dac_pkg::REG_CTRL) begin
      d.extMode = avs_writedata[dac_pkg::CTRL_EXT];
      d.rowHold = avs_writedata[dac_pkg::CTRL_HOLD];
      d.autoRef = avs_writedata[dac_pkg::CTRL_AUTO];
      if (avs_writedata[dac_pkg::CTRL_CLR]) begin
        d.clrCnt = dac_pkg::CLR_LEN;
        d.refCount = 16'h0000;
      end
    end
    if (avs_write && avs_address == dac_pkg::REG_ADDR) begin
      d.addr = avs_writedata[ADDR_W-1:0];
    end
    case (q.st)
      dac_pkg::ST_IDLE: begin
        // park in the chosen access mode, strobes high
        d.mode = q.extMode ? dac_pkg::MODE_EXT_ACC
                           : dac_pkg::MODE_AUTO;
        d.rcSel = 1'b1;
        if (q.refPend) begin
          refClr = 1'b1;
          if (q.extMode || !q.autoRef) begin
            // system timed refresh, row strobe driven by us
            d.mode = q.extMode ? dac_pkg::MODE_EXT_REF
                               : dac_pkg::MODE_FORCED;
            d.cnt = RF_SETUP;
            d.st = dac_pkg::ST_EXT_SET;
          end else begin
            // forced refresh, device makes its own row strobes
            d.mode = dac_pkg::MODE_FORCED;
            d.cnt = FORCE_MAX;
            d.st = dac_pkg::ST_FORCE;
          end
        end else if (cmdGo) begin
          d.isWrite = avs_writedata[dac_pkg::CMD_WR];
          d.rowN = 1'b0;
          // write input level set before column strobe falls
          d.winN = ~avs_writedata[dac_pkg::CMD_WR];
          if (q.extMode) begin
            d.cnt = ROW_HOLD;
            d.st = dac_pkg::ST_ACC_ROW;
          end else begin
            // one strobe is all the automatic mode needs
            d.cnt = AUTO_LOW;
            d.st = dac_pkg::ST_AUTO;
          end
        end
      end
      dac_pkg::ST_ACC_ROW: begin
        // row address on outputs until hold time has passed
        if (q.cnt == 8'h00) begin
          d.rcSel = 1'b0;
          // column strobe input low as select falls: auto strobe
          d.colN = 1'b0;
          d.cnt = COL_LOW;
          d.st = dac_pkg::ST_ACC_COL;
        end
      end
      dac_pkg::ST_ACC_COL: begin
        // single access only; page toggling is left to software
        if (q.cnt == 8'h00) begin
          d.rowN = 1'b1;
          d.colN = 1'b1;
          d.winN = 1'b1;
          d.rcSel = 1'b1;
          d.cnt = PRECH;
          d.st = dac_pkg::ST_PRECH;
        end
      end
      dac_pkg::ST_AUTO: begin
        // device switches address and column strobe by itself
        if (q.cnt == 8'h00) begin
          d.rowN = 1'b1;
          d.winN = 1'b1;
          d.cnt = PRECH;
          d.st = dac_pkg::ST_PRECH;
        end
      end
      dac_pkg::ST_PRECH: begin
        // row strobe high long enough before any new cycle
        if (q.cnt == 8'h00) begin
          d.st = dac_pkg::ST_IDLE;
        end
      end
      dac_pkg::ST_EXT_SET: begin
        // refresh select settles before the row strobe falls
        if (q.cnt == 8'h00) begin
          d.rowN = 1'b0;
          d.cnt = RAS_LOW;
          d.st = dac_pkg::ST_EXT_RAS;
        end
      end
      dac_pkg::ST_EXT_RAS: begin
        if (q.cnt == 8'h00) begin
          // rising row strobe advances the device counter
          d.rowN = 1'b1;
          d.refCount = q.refCount + 16'h0001;
          d.st = dac_pkg::ST_EXT_END;
        end
      end
      dac_pkg::ST_EXT_END: begin
        // leave refresh mode one cycle after the strobe rose
        d.mode = q.extMode ? dac_pkg::MODE_EXT_ACC
                           : dac_pkg::MODE_AUTO;
        d.cnt = PRECH;
        d.st = dac_pkg::ST_PRECH;
      end
      dac_pkg::ST_FORCE: begin
        // request released as row strobes fall; timeout if lost
        if (q.ioS2 || q.cnt == 8'h00) begin
          d.cnt = RAS_LOW;
          d.st = dac_pkg::ST_FORCE_HOLD;
        end
      end
      dac_pkg::ST_FORCE_HOLD: begin
        // ending early, but never below the row strobe low time
        if (q.cnt == 8'h00) begin
          d.mode = dac_pkg::MODE_AUTO;
          d.refCount = q.refCount + 16'h0001;
          d.cnt = PRECH;
          d.st = dac_pkg::ST_PRECH;
        end
      end
      default: begin
        d.st = dac_pkg::ST_IDLE;
      end
    endcase
    // an owed refresh that arrives while taken is kept
    d.refPend = refSet | (q.refPend & ~refClr);
  end

  // state register, constants only under reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= dac_pkg::ST_IDLE;
      q.extMode <= dac_pkg::CTRL_EXT_RST;
      q.rowHold <= dac_pkg::CTRL_HOLD_RST;
      q.autoRef <= dac_pkg::CTRL_AUTO_RST;
      q.ioS1 <= 1'b1;
      q.ioS2 <= 1'b1;
      q.ioPrev <= 1'b1;
      q.rowN <= 1'b1;
      q.colN <= 1'b1;
      q.winN <= 1'b1;
      q.rcSel <= 1'b1;
      q.mode <= dac_pkg::MODE_AUTO;
    end else begin
      q <= d;
    end
  end

  // pins; in automatic mode one pin carries the strobe clock, the other the cycle clock if auto refresh is on
  assign colStrobeOrRefClk = q.extMode ? q.colN : strobeClk;
  assign rowColOrCycleClk = q.extMode ? q.rcSel
    : (q.autoRef ? cycleClk : 1'b1);
  assign rowStrobeInN = q.rowN;
  assign writeInN = q.winN;
  assign refreshModePin = q.mode[1];
  assign lowModePin = q.mode[0];
  assign rowHoldSelect = q.rowHold;
  assign memAddr = q.addr;
  assign avs_readdata = q.rdata;
  // open drain pull of the refresh io pin resets the counter
  assign refreshIoOut = 1'b0;
  assign refreshIoOe = (q.clrCnt > dac_pkg::CLR_DRIVE);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // refresh modes only in refresh states
  a_mode_pair: assert property (
    !q.mode[1] |-> (q.st inside {dac_pkg::ST_EXT_SET, dac_pkg::ST_EXT_RAS,
      dac_pkg::ST_EXT_END, dac_pkg::ST_FORCE, dac_pkg::ST_FORCE_HOLD}))
    else $error("refresh mode outside a refresh");

  // forced refresh finishes in bounded time
  a_force_bound: assert property (
    $rose(q.st == dac_pkg::ST_FORCE)
      |-> ##[1:FORCE_LIM] (q.st == dac_pkg::ST_FORCE_HOLD))
    else $error("forced refresh never released");

  // forced mode held through the row strobe low time
  a_ras_low: assert property (
    $rose(q.st == dac_pkg::ST_FORCE_HOLD) |-> !q.mode[1] [*8])
    else $error("forced refresh ended too early");

  // precharge follows every return to access mode
  a_precharge: assert property (
    $rose(q.mode[1]) |-> (q.rowN && q.st == dac_pkg::ST_PRECH)
      ##[PRECH_MIN:PRECH_LIM] (q.st == dac_pkg::ST_IDLE))
    else $error("precharge not kept after refresh");

  // commands wait while refresh owed
  a_wait_ref: assert property (
    (cmdHit && q.refPend) |-> avs_waitrequest)
    else $error("access let through during refresh");

  // row hold time before select falls
  a_row_hold: assert property (
    ($fell(q.rowN) && q.extMode && q.st == dac_pkg::ST_ACC_ROW)
      |-> q.rcSel [*3] ##1 !q.rcSel)
    else $error("select fell before row hold time");

  // column strobe low only with column address
  a_col_sel: assert property (
    (q.extMode && !q.colN) |-> (!q.rcSel && !q.rowN))
    else $error("column strobe low with row select");

  // external access refreshes only in mode zero
  a_ext_ref: assert property (
    (q.extMode && !q.mode[1]) |-> !q.mode[0])
    else $error("forced refresh in external access");

  // automatic access holds row strobe low for at least eight cycles
  a_auto_low: assert property (
    $rose(q.st == dac_pkg::ST_AUTO) |-> !q.rowN [*8])
    else $error("automatic access strobe too short");

  // counter copy advances as row strobe rises
  a_ref_count: assert property (
    (q.st == dac_pkg::ST_EXT_RAS && q.cnt == 8'h00)
      |=> (q.refCount == $past(q.refCount) + 16'h0001) && q.rowN)
    else $error("refresh count not advanced");

  c_ext_access: cover property (q.st == dac_pkg::ST_ACC_COL);
  c_auto_access: cover property (q.st == dac_pkg::ST_AUTO);
  c_forced: cover property (q.st == dac_pkg::ST_FORCE_HOLD);
  c_ext_refresh: cover property (q.st == dac_pkg::ST_EXT_RAS);
endmodule

// *** rtl/dac_pkg.sv ***
// Purpose: constants, states and register map of the dram host controller
// Assumes: ref_clk at 100 MHz, one clock domain
// Notes: the controller drives the strobe and mode pins of the dram driver
//
// Overview of operation
// - two mode pins pick one of four modes
// - early refresh end keeps minimum row strobe low
// - precharge time kept before access follows refresh
// - accesses wait while forced refresh runs
// - request released as row strobes fall
// - wait row hold time before select falls
// - column strobe toggling gives page accesses; the controller makes single accesses only
// - external access uses external refresh only
// - automatic access needs only row strobe low
// - refresh clock held high allows external refresh
// - hidden refresh combines with forced or external; the controller pairs it with forced refresh only
package dac_pkg;
  // clock and analogue times, cycles rounded up for least times
  localparam int CLK_NS = 10;
  localparam int ROW_HOLD_NS = 15;
  localparam int COL_LOW_NS = 60;
  localparam int PRECHARGE_NS = 60;
  localparam int RAS_LOW_NS = 80;
  localparam int AUTO_LOW_NS = 120;
  localparam int REFRESH_SELECT_SETUP_NS = 20;
  localparam int FORCE_MAX_NS = 500;
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_LOW_CYC = (COL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_LOW_CYC = (RAS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int AUTO_LOW_CYC = (AUTO_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_SELECT_SETUP_CYC = (REFRESH_SELECT_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FORCE_MAX_CYC = FORCE_MAX_NS / CLK_NS;
  // refresh clock generator defaults: 100 ns strobe clock, 16 us cycle
  localparam int STROBE_HALF = 5;
  localparam int CYCLE_PERIOD = 1600;
  localparam int CYCLE_HIGH = 1200;
  // mode pin pairs {refresh mode pin, low mode pin}
  localparam logic [1:0] MODE_EXT_REF = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [1:0] MODE_EXT_ACC = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  // register word indices on the avalon slave
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_CMD = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  // control and command bit positions
  localparam int CTRL_EXT = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_CLR = 3;
  localparam int CMD_GO = 0;
  localparam int CMD_WR = 1;
  // control reset: automatic access, auto refresh on, long hold
  localparam logic CTRL_EXT_RST = 1'h0;
  localparam logic CTRL_HOLD_RST = 1'h1;
  localparam logic CTRL_AUTO_RST = 1'h1;
  // counter reset pulse: driven while above CLR_DRIVE, masked to zero
  localparam logic [3:0] CLR_LEN = 4'h6;
  localparam logic [3:0] CLR_DRIVE = 4'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACC_ROW, ST_ACC_COL, ST_AUTO, ST_PRECH,
    ST_EXT_SET, ST_EXT_RAS, ST_EXT_END, ST_FORCE, ST_FORCE_HOLD
  } dac_state_t;
endpackage

// *** rtl/dac_clk_gen.sv ***
// Purpose: refresh cycle clock and refresh strobe clock for the driver
// Assumes: ref_clk at 100 MHz
// Notes: both clocks come from flip-flops, so no glitches reach the pins
`timescale 1ns/100ps
module dac_clk_gen #(
  parameter int STROBE_HALF = dac_pkg::STROBE_HALF,
  parameter int CYCLE_PERIOD = dac_pkg::CYCLE_PERIOD,
  parameter int CYCLE_HIGH = dac_pkg::CYCLE_HIGH
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic strobeClk,
  output logic cycleClk,
  output logic cycleFall
);
  // whole state of the generator
  typedef struct packed {
    logic [7:0] sCnt;
    logic [15:0] cCnt;
    logic sClk;
    logic cClk;
    logic fall;
  } dac_gen_t;
  dac_gen_t q, d;

  // next state: free running counters
  always_comb begin
    d = q;
    d.fall = 1'b0;
    if (q.sCnt == 8'(STROBE_HALF - 1)) begin
      d.sCnt = 8'h00;
      d.sClk = ~q.sClk;
    end else begin
      d.sCnt = q.sCnt + 8'h01;
    end
    if (q.cCnt == 16'(CYCLE_PERIOD - 1)) begin
      d.cCnt = 16'h0000;
    end else begin
      d.cCnt = q.cCnt + 16'h0001;
    end
    // high for the first part of the period, low for the rest
    d.cClk = (d.cCnt < 16'(CYCLE_HIGH));
    d.fall = q.cClk & ~d.cClk;
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign strobeClk = q.sClk;
  assign cycleClk = q.cClk;
  assign cycleFall = q.fall;
endmodule

// *** tb/dac_drv_model.sv ***
// Purpose: behavioural model of the mode controlled dram driver
// Assumes: pins sampled on ref_clk, refresh io wire has a pull-up
// Notes: only refresh logic is modelled; access strobes pass by
`timescale 1ns/100ps
module dac_drv_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rasInN,
  input wire logic strobeClk,
  input wire logic cycleClk,
  input wire logic modeHi,
  input wire logic modeLo,
  input wire logic ioLevel,
  output logic devPull,
  output logic [15:0] refCnt
);
  logic [2:0] prev; // last row strobe, strobe clock, cycle clock
  logic [2:0] falls; // strobe clock falls since forced entry
  logic gen; // own row strobe low during forced refresh
  logic done; // a refresh was seen while the cycle clock was high
  logic [1:0] mode;
  logic sFall; // strobe clock fell this cycle
  assign mode = {modeHi, modeLo};
  assign sFall = prev[1] && !strobeClk;
  // all refresh state in one process, sampled like the real pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev <= 3'h0; // zero, so no edge is invented after reset
      falls <= 3'h0;
      gen <= 1'b0;
      done <= 1'b0;
      devPull <= 1'b0;
      refCnt <= 16'h0;
    end else begin
      prev <= {rasInN, strobeClk, cycleClk};
      falls <= 3'h0;
      if (mode == 2'h1 && (!cycleClk || gen)) begin
        falls <= falls + {2'h0, sFall};
        if (sFall && falls == 3'h1) begin
          gen <= 1'b1; // second fall starts the strobe
          devPull <= 1'b0;
        end
        if (sFall && falls == 3'h3) begin
          gen <= 1'b0; // two falls later it ends
          refCnt <= refCnt + 16'h1;
        end
      end else if (gen) begin
        gen <= 1'b0; // early end as the mode pin rises
        refCnt <= refCnt + 16'h1;
      end else if (!modeHi && !prev[2] && rasInN) begin
        refCnt <= refCnt + 16'h1;
        if (cycleClk) begin
          done <= 1'b1;
        end
      end
      if (modeLo && prev[0] && !cycleClk) begin
        devPull <= !done;
        done <= 1'b0;
      end
      if (mode == 2'h0) begin
        devPull <= 1'b0;
      end
      if (!ioLevel && !devPull) begin
        refCnt <= 16'h0; // wire pulled by the far side clears
      end
    end
  end
endmodule

// *** tb/dac_host_ctrl_tb.sv ***
// Purpose: self-checking bench of the dram host controller
// Assumes: driver model on the pins, pull-up on the refresh wire
// Notes: reads are checked from a queue, pin timing inline
`timescale 1ns/100ps
module dac_host_ctrl_tb;
  localparam int PER = 128; // short refresh period keeps runs brief
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [19:0] memAddr;
  logic rowStrobeInN, colStrobeOrRefClk, rowColOrCycleClk, writeInN;
  logic refreshModePin, lowModePin, rowHoldSelect, refreshIoOe;
  logic devPull, ioLevel;
  logic [15:0] devCnt;
  logic [15:0] rnd = 16'h23; // lfsr seed
  logic [31:0] expQ[$]; // read data owed, oldest first
  int error_cnt = 0;
  int cmp_count = 0;
  int sinceRef = 0; // cycles since the mode pin rose
  int lowRun = 0; // cycles of the running refresh mode
  int refLow = 0; // length of the last refresh mode
  int oeCnt = 0; // cycles of counter reset pull
  // open-drain wire: either side pulls low, else the pull-up wins
  assign ioLevel = !(devPull === 1'b1 || refreshIoOe === 1'b1);
  // free running reference clock
  initial begin
    forever #5 ref_clk = !ref_clk;
  end
  dac_host_ctrl #(.ADDR_W(20), .CYCLE_PERIOD(PER), .CYCLE_HIGH(PER / 2))
    i_dac_host_ctrl (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .memAddr(memAddr), .rowStrobeInN(rowStrobeInN),
    .colStrobeOrRefClk(colStrobeOrRefClk),
    .rowColOrCycleClk(rowColOrCycleClk), .writeInN(writeInN),
    .refreshModePin(refreshModePin), .lowModePin(lowModePin),
    .rowHoldSelect(rowHoldSelect), .refreshIoIn(ioLevel),
    .refreshIoOut(), .refreshIoOe(refreshIoOe));
  dac_drv_model i_dac_drv_model (.ref_clk(ref_clk), .reset(reset),
    .rasInN(rowStrobeInN), .strobeClk(colStrobeOrRefClk),
    .cycleClk(rowColOrCycleClk), .modeHi(refreshModePin),
    .modeLo(lowModePin), .ioLevel(ioLevel), .devPull(devPull),
    .refCnt(devCnt));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // driver pins packed for one comparison
  function automatic logic [31:0] pins();
    return {26'h0, rowStrobeInN, writeInN, rowColOrCycleClk,
      colStrobeOrRefClk, refreshModePin, lowModePin};
  endfunction
  task wrap_up();
    $display("errors %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_rd(input logic [31:0] e, input logic [31:0] g);
    chk("readdata", e, g);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic [1:0] a, input logic w, input logic [31:0] d);
    int n;
    logic wq;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // waitrequest looked at mid-cycle, where it has settled
    do begin
      @(negedge ref_clk);
      wq = avs_waitrequest;
      @(posedge ref_clk);
      n++;
    end while (wq !== 1'b0 && n < 400);
    if (n >= 400) chk("waitrequest", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // bounded wait for the mode pin to reach a level
  task wait_ref(input logic lvl);
    int t;
    t = 0;
    while (refreshModePin !== lvl && t < 1000) begin
      @(negedge ref_clk);
      t++;
    end
    if (t >= 1000) chk("refreshModePin", {31'h0, lvl}, {31'h0, !lvl});
  endtask
  // length of the next row strobe low, and precharge before it
  task span(output int n, output int pre);
    int t;
    t = 0;
    n = 0;
    @(negedge ref_clk);
    while (rowStrobeInN !== 1'b0 && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
    pre = sinceRef;
    while (rowStrobeInN === 1'b0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // read results are compared mid-cycle before the taking edge
  always @(negedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0)
      chk_rd(expQ.pop_front(), avs_readdata);
  end
  // refresh and counter reset timing, sampled mid-cycle
  always @(negedge ref_clk) begin
    sinceRef <= refreshModePin ? sinceRef + 1 : 0;
    lowRun <= refreshModePin ? 0 : lowRun + 1;
    if (refreshModePin && lowRun > 0) refLow <= lowRun;
    if (refreshIoOe === 1'b1) oeCnt <= oeCnt + 1;
  end
  // whole run is well under a thousand cycles, so this only cuts hangs
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    int n, pre;
    logic wr;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("resetPins", 32'h33, pins() | {31'h0, refreshIoOe});
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(dac_pkg::REG_CTRL, 32'h6);
    rd(dac_pkg::REG_STAT, 32'h8);
    bus(dac_pkg::REG_STAT, 1'b1, 32'hffff_ffff);
    rd(dac_pkg::REG_STAT, 32'h8);
    n = 0;
    @(negedge ref_clk);
    for (int i = 0; i < 100; i++) begin
      wr = colStrobeOrRefClk;
      @(negedge ref_clk);
      if (colStrobeOrRefClk !== wr) n++;
    end
    chk("strobeToggles", 32'h14, n);
    bus(dac_pkg::REG_CTRL, 1'b1, 32'h4);
    repeat (80) @(negedge ref_clk);
    chk("rowHoldSelect", 32'h0, {31'h0, rowHoldSelect});
    bus(dac_pkg::REG_CTRL, 1'b1, 32'h6);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr = rnd[0];
      bus(dac_pkg::REG_ADDR, 1'b1, {12'h0, rnd[3:0], rnd});
      bus(dac_pkg::REG_CMD, 1'b1, {30'h0, wr, 1'b1});
      span(n, pre);
      chk("memAddr", {12'h0, rnd[3:0], rnd}, {12'h0, memAddr});
      chk("autoRowLow", 32'hd, n);
    end
    wait_ref(1'b0);
    chk("forcedMode", 32'h1, {31'h0, lowModePin});
    bus(dac_pkg::REG_CMD, 1'b1, 32'h1);
    chk("stalledPin", 32'h1, {31'h0, refreshModePin});
    span(n, pre);
    chk("precharge", 32'h1, pre >= dac_pkg::PRECHARGE_CYC);
    chk("forcedLen", 32'h1, refLow <= dac_pkg::FORCE_MAX_CYC + 12);
    wait_ref(1'b0);
    wait_ref(1'b1);
    repeat (9) @(negedge ref_clk);
    rd(dac_pkg::REG_STAT, {devCnt, 16'h8});
    bus(dac_pkg::REG_CTRL, 1'b1, 32'h7);
    for (int i = 0; i < 2; i++) begin
      wr = i[0];
      bus(dac_pkg::REG_CMD, 1'b1, {30'h0, wr, 1'b1});
      repeat (2) @(negedge ref_clk);
      chk("extStart", {26'h0, 1'b0, !wr, 4'he}, pins());
      repeat (3) @(negedge ref_clk);
      chk("extColumn", {26'h0, 1'b0, !wr, 4'h2}, pins());
      repeat (7) @(negedge ref_clk);
      chk("extEnd", 32'h3e, pins());
    end
    wait_ref(1'b0);
    chk("extRefMode", 32'h0, {31'h0, lowModePin});
    span(n, pre);
    chk("extRefLow", 32'h9, n);
    wait_ref(1'b1);
    repeat (9) @(negedge ref_clk);
    rd(dac_pkg::REG_STAT, {devCnt, 16'h9});
    oeCnt = 0;
    bus(dac_pkg::REG_CTRL, 1'b1, 32'hf);
    repeat (8) @(negedge ref_clk);
    chk("clearPulse", 32'h4, oeCnt);
    chk("devCount", 32'h0, {16'h0, devCnt});
    rd(dac_pkg::REG_STAT, 32'h9);
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule
